// ==== common/sleep_pkg.sv ====
// shared constants and types of the sleep-mode controller
package sleep_pkg;
   // register byte addresses on the register bus
   localparam logic [3:0] SLEEP_CTRL_ADDR = 4'h0;
   localparam logic [3:0] MICRO_CTRL_ADDR = 4'h4;
   localparam logic [3:0] STATUS_ADDR = 4'h8;
   localparam logic [3:0] CONFIG_ADDR = 4'hC;
   // field positions
   localparam int SE_POS = 0;
   localparam int SM_LO_POS = 1;
   localparam int BROWNOUT_OFF_UNLOCK_POS = 5;
   localparam int BROWNOUT_SLEEP_OFF_POS = 6;
   localparam int AS0_POS = 0;
   localparam int STARTUP_LO_POS = 8;
   // reset values
   localparam logic [7:0] SLEEP_CTRL_RST = 8'h00;
   localparam logic [7:0] STARTUP_RST = 8'h10;
   // timing
   localparam int CLK_MHZ = 10;
   localparam int CORE_HOLD_CYC = 4;
   localparam int UNLOCK_WIN_CYC = 4;
   localparam int BROWNOUT_SLEEP_OFF_LIFE_CYC = 3;
   localparam int BOD_WAKE_US = 60;
   localparam int BOD_WAKE_CYC = BOD_WAKE_US * CLK_MHZ;
   localparam int CNT_W = 10;

   typedef enum logic [1:0]
   {
      MODE_IDLE = 2'h0,
      MODE_ADC_NR = 2'h1,
      MODE_PWR_DOWN = 2'h2,
      MODE_PWR_SAVE = 2'h3
   } sleep_mode_t;

   // gated clock enables and oscillator enables
   typedef struct packed
   {
      logic core_clock;
      logic program_memory_clock;
      logic peripheral_clock;
      logic converter_clock;
      logic asynchronous_clock;
      logic main_osc;
      logic timer_osc;
   } clock_gates_t;

   // interrupt request sources able to wake the device
   typedef struct packed
   {
      logic adc_done;
      logic watchdog_irq;
      logic start_cond;
      logic timer0_ovf;
      logic timer0_cmp;
      logic nvm_ready;
      logic ext_irq_zero;
      logic ext_irq_one;
      logic pin_change;
      logic other_io;
   } wake_src_t;

   // timer0 interrupt enables, global enable and external pin sense
   typedef struct packed
   {
      logic timer0_ovf_en;
      logic timer0_cmp_en;
      logic global_ie;
      logic ext_zero_level;
      logic ext_one_level;
   } wake_cfg_t;
endpackage : sleep_pkg

// ==== design/wake_filter.sv ====
// wake-source qualifier per sleep mode
`timescale 1ns/100ps
`default_nettype none
module wake_filter
   import sleep_pkg::*;
(
   // mode and sources
   input wire sleep_mode_t mode,
   input wire wake_src_t src,
   input wire wake_cfg_t cfg,
   input wire logic timer0_async_select,
   // result
   output logic wake
);
   logic ext_lvl;
   logic timer_evt;

   // deep modes see the external pins only in level mode
   assign ext_lvl = (src.ext_irq_zero & cfg.ext_zero_level)
                  | (src.ext_irq_one & cfg.ext_one_level); // RL12
   assign timer_evt = ((src.timer0_ovf & cfg.timer0_ovf_en)
                     | (src.timer0_cmp & cfg.timer0_cmp_en)) & cfg.global_ie;

   always_comb
   begin
      unique case (mode)
         MODE_IDLE:
            wake = |src; // RL9
         MODE_ADC_NR:
            wake = src.adc_done | src.watchdog_irq | src.start_cond | src.timer0_ovf
                 | src.timer0_cmp | src.nvm_ready | ext_lvl | src.pin_change; // RL10
         MODE_PWR_DOWN:
            wake = src.watchdog_irq | src.start_cond | ext_lvl | src.pin_change; // RL11
         MODE_PWR_SAVE:
            wake = src.watchdog_irq | src.start_cond | ext_lvl | src.pin_change
                 | (timer_evt & timer0_async_select); // RL16
      endcase
   end
endmodule : wake_filter
`default_nettype wire

// ==== design/sleep_mode_controller.sv ====
// sleep-mode controller: entry, clock gating, wake-up and brown-out switch-off
// Behaviour
// [RL1] software sets sleep enable before the sleep instruction to enter the chosen mode
// [RL2] mode 00 idle stops core and program memory clocks only
// [RL3] mode 01 adds stopping the peripheral clock
// [RL4] mode 10 stops main oscillator and all generated clocks
// [RL5] mode 11 like power-down but keeps async clock and timer oscillator
// [RL6] interrupt wake holds core four cycles beyond clock start-up
// [RL7] register file and SRAM untouched across sleep
// [RL8] reset during sleep wakes to the reset vector
// [RL9] idle accepts every enabled interrupt as wake source
// [RL10] noise reduction wakes only on the listed sources
// [RL11] power-down wakes only on the listed sources
// [RL12] deep modes wake on external pins only in level mode
// [RL13] external level must be held long enough by the waking party
// [RL14] enabled converter starts a conversion on idle or noise-reduction entry
// [RL15] power-down wake waits the fuse-defined start-up period
// [RL16] power-save wakes on timer0 events when async and enabled
// [RL17] software avoids power-save without async timer0 clock
// [RL18] brown-out switch-off only in power-down and power-save
// [RL19] detector off after sleep entry, back on at wake-up
// [RL20] wake extended to 60 us after detector was off
// [RL21] brown-out sleep bit resets to zero
// [RL22] unlock write then set within four cycles
// [RL23] brown-out sleep bit self-clears after three cycles
// [RL24] sleep instruction without sleep enable does nothing
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_controller
   import sleep_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // core side
   input wire logic sleep_instr,
   input wire logic sys_reset,
   input wire logic adc_enabled,
   input wire wake_src_t wake_src,
   input wire wake_cfg_t wake_cfg,
   input wire logic timer0_async_select,
   // outputs to clock tree and peripherals
   output clock_gates_t clk_gates,
   output logic brownout_detector_on,
   output logic adc_start,
   output logic core_resume,
   output logic core_reset_vector,
   output logic asleep
);
   typedef enum logic [4:0]
   {
      ST_RUN = 5'h01,
      ST_SLEEP = 5'h02,
      ST_STARTUP = 5'h04,
      ST_HOLD = 5'h08,
      ST_BOOT = 5'h10
   } state_t;

   state_t state_r;
   logic sleep_enable_bit_r;
   sleep_mode_t sleep_mode_select_r;
   sleep_mode_t cur_mode_r;
   logic brownout_sleep_off_r;
   logic brownout_off_unlock_r;
   logic [2:0] unlock_cnt_r;
   logic [1:0] brownout_sleep_off_cnt_r;
   logic [7:0] startup_cyc_r;
   logic bod_was_off_r;
   logic [CNT_W-1:0] wait_cnt_r;
   logic wake;
   logic deep_mode;
   logic bus_req;
   logic bus_wr;
   logic [31:0] rd_nxt;

   wake_filter u_wake
   (
      .mode(cur_mode_r),
      .src(wake_src),
      .cfg(wake_cfg),
      .timer0_async_select(timer0_async_select),
      .wake(wake)
   );

   assign deep_mode = cur_mode_r[1];
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

   // bus ack: one cycle after the request, dropped the next cycle
   // a write lands at the edge that raises ack, while the master still holds
   // the request; masking with ack keeps that held request from landing twice
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         wb_ack_o <= 1'b0;
      else if (clk_en)
         wb_ack_o <= bus_req;
   end

   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      unique case (wb_adr_i)
         SLEEP_CTRL_ADDR:
         begin
            rd_nxt[SE_POS] = sleep_enable_bit_r;
            rd_nxt[SM_LO_POS +: 2] = sleep_mode_select_r;
         end
         MICRO_CTRL_ADDR:
         begin
            rd_nxt[BROWNOUT_OFF_UNLOCK_POS] = brownout_off_unlock_r;
            rd_nxt[BROWNOUT_SLEEP_OFF_POS] = brownout_sleep_off_r;
         end
         STATUS_ADDR:
         begin
            rd_nxt[4:0] = state_r;
            rd_nxt[6:5] = cur_mode_r;
            rd_nxt[7] = brownout_detector_on;
         end
         CONFIG_ADDR:
            rd_nxt[STARTUP_LO_POS +: 8] = startup_cyc_r;
         default:
            rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
         wb_dat_o <= 32'h0000_0000;
      else if (clk_en && bus_req)
         wb_dat_o <= rd_nxt;
   end

   // sleep control register
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         sleep_enable_bit_r <= SLEEP_CTRL_RST[SE_POS];
         sleep_mode_select_r <= sleep_mode_t'(SLEEP_CTRL_RST[SM_LO_POS +: 2]);
      end
      else if (clk_en && bus_wr && wb_adr_i == SLEEP_CTRL_ADDR)
      begin
         sleep_enable_bit_r <= wb_dat_i[SE_POS];
         sleep_mode_select_r <= sleep_mode_t'(wb_dat_i[SM_LO_POS +: 2]);
      end
   end

   // start-up period in cycles; stands in for the clock-select fuses
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         startup_cyc_r <= STARTUP_RST;
      else if (clk_en && wb_sel_i[1] && bus_req && wb_we_i && wb_adr_i == CONFIG_ADDR)
         startup_cyc_r <= wb_dat_i[STARTUP_LO_POS +: 8];
   end

   // timed unlock: the set write only counts inside the window
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         brownout_off_unlock_r <= 1'b0;
         unlock_cnt_r <= 3'h0;
      end
      else if (clk_en)
      begin
         if (bus_wr && wb_adr_i == MICRO_CTRL_ADDR
             && wb_dat_i[BROWNOUT_SLEEP_OFF_POS] && wb_dat_i[BROWNOUT_OFF_UNLOCK_POS] && !brownout_off_unlock_r)
         begin
            brownout_off_unlock_r <= 1'b1; // RL22
            unlock_cnt_r <= 3'(UNLOCK_WIN_CYC);
         end
         else if (brownout_off_unlock_r)
         begin
            // rewriting the unlock does not extend the window
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
            if (unlock_cnt_r == 3'h1 || (bus_wr && wb_adr_i == MICRO_CTRL_ADDR
                                         && !wb_dat_i[BROWNOUT_OFF_UNLOCK_POS]))
               brownout_off_unlock_r <= 1'b0;
         end
      end
   end

   // brown-out sleep bit: resets to zero, self-clears after three cycles
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         brownout_sleep_off_r <= 1'b0; // RL21
         brownout_sleep_off_cnt_r <= 2'h0;
      end
      else if (clk_en)
      begin
         if (bus_wr && wb_adr_i == MICRO_CTRL_ADDR && brownout_off_unlock_r
             && wb_dat_i[BROWNOUT_SLEEP_OFF_POS] && !wb_dat_i[BROWNOUT_OFF_UNLOCK_POS])
         begin
            brownout_sleep_off_r <= 1'b1; // RL22
            brownout_sleep_off_cnt_r <= 2'(BROWNOUT_SLEEP_OFF_LIFE_CYC);
         end
         else if (brownout_sleep_off_r)
         begin
            brownout_sleep_off_cnt_r <= brownout_sleep_off_cnt_r - 2'h1;
            if (brownout_sleep_off_cnt_r == 2'h1)
               brownout_sleep_off_r <= 1'b0; // RL23
         end
      end
   end

   // sequencer; the register file and SRAM are never touched here
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         state_r <= ST_RUN;
         cur_mode_r <= MODE_IDLE;
         bod_was_off_r <= 1'b0;
         wait_cnt_r <= '0;
      end
      else if (clk_en)
      begin
         unique case (state_r)
            ST_RUN:
               if (sleep_instr && sleep_enable_bit_r) // RL1 RL24
               begin
                  state_r <= ST_SLEEP;
                  cur_mode_r <= sleep_mode_select_r;
                  bod_was_off_r <= brownout_sleep_off_r & sleep_mode_select_r[1]; // RL18
               end
            ST_SLEEP:
               if (sys_reset)
                  state_r <= ST_BOOT; // RL8
               else if (wake)
               begin
                  state_r <= ST_STARTUP;
                  if (bod_was_off_r)
                     wait_cnt_r <= CNT_W'(BOD_WAKE_CYC); // RL20
                  else if (deep_mode)
                     wait_cnt_r <= CNT_W'(startup_cyc_r); // RL15
                  else
                     wait_cnt_r <= '0;
               end
            ST_STARTUP:
               if (sys_reset)
                  state_r <= ST_BOOT;
               else if (wait_cnt_r == '0)
               begin
                  state_r <= ST_HOLD;
                  wait_cnt_r <= CNT_W'(CORE_HOLD_CYC - 1); // RL6
               end
               else
                  wait_cnt_r <= wait_cnt_r - 1'b1;
            ST_HOLD:
               if (sys_reset)
                  state_r <= ST_BOOT;
               else if (wait_cnt_r == '0)
               begin
                  state_r <= ST_RUN;
                  bod_was_off_r <= 1'b0;
               end
               else
                  wait_cnt_r <= wait_cnt_r - 1'b1;
            ST_BOOT:
            begin
               // restart from the vector: no sleep mode or count survives
               state_r <= ST_RUN;
               cur_mode_r <= MODE_IDLE;
               wait_cnt_r <= '0;
               bod_was_off_r <= 1'b0;
            end
         endcase
      end
   end

   // clock gating, registered so outputs come from flip-flops
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         clk_gates <= 7'h7F;
      else if (clk_en)
      begin
         if (state_r == ST_SLEEP)
         begin
            clk_gates.core_clock <= 1'b0;
            clk_gates.program_memory_clock <= 1'b0; // RL2
            clk_gates.peripheral_clock <= (cur_mode_r == MODE_IDLE); // RL3
            clk_gates.converter_clock <= !deep_mode; // RL4
            clk_gates.main_osc <= !deep_mode;
            clk_gates.asynchronous_clock <= (cur_mode_r != MODE_PWR_DOWN); // RL5
            clk_gates.timer_osc <= (cur_mode_r != MODE_PWR_DOWN);
         end
         else
         begin
            // oscillators back during start-up, core only after the hold
            clk_gates <= 7'h7F;
            clk_gates.core_clock <= (state_r == ST_RUN || state_r == ST_BOOT);
            clk_gates.program_memory_clock <= (state_r == ST_RUN || state_r == ST_BOOT);
         end
      end
   end

   // detector off only while asleep with the switch-off latched
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         brownout_detector_on <= 1'b1;
      else if (clk_en)
         brownout_detector_on <= !(state_r == ST_SLEEP && bod_was_off_r); // RL19
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         adc_start <= 1'b0;
         core_resume <= 1'b0;
         core_reset_vector <= 1'b0;
         asleep <= 1'b0;
      end
      else if (clk_en)
      begin
         adc_start <= state_r == ST_RUN && sleep_instr && sleep_enable_bit_r
                      && adc_enabled && !sleep_mode_select_r[1]; // RL14
         core_resume <= state_r == ST_HOLD && wait_cnt_r == '0 && !sys_reset; // RL6
         core_reset_vector <= state_r != ST_RUN && state_r != ST_BOOT && sys_reset; // RL8
         asleep <= state_r == ST_SLEEP; // RL7
      end
   end
endmodule : sleep_mode_controller
`default_nettype wire

// ==== verification/sleep_mode_controller_asserts.sv ====
// port checker for the sleep-mode controller
`timescale 1ns/100ps
`default_nettype none
module sleep_mode_controller_asserts
   import sleep_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // core side and outputs
   input wire logic sleep_instr,
   input wire logic sys_reset,
   input wire logic adc_enabled,
   input wire wake_src_t wake_src,
   input wire clock_gates_t clk_gates,
   input wire logic brownout_detector_on,
   input wire logic adc_start,
   input wire logic core_resume,
   input wire logic core_reset_vector,
   input wire logic asleep
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // shadow of enable and mode, caught one edge late at the acked write
   logic [2:0] ctrl_r;
   logic take;
   always_ff @(posedge mclk)
      if (!rstn)
         ctrl_r <= 3'h0;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
               && wb_adr_i == SLEEP_CTRL_ADDR)
         ctrl_r <= wb_dat_i[2:0];
   assign take = sleep_instr && !asleep;
   sequence s_hold;
      (!core_resume) [*4];
   endsequence
   sequence s_resume;
      ##[0:7] core_resume;
   endsequence
   a_sleep_entry: assert property (take && ctrl_r[0] |=> ##1 asleep)
      else $error("sleep not entered");
   a_enable_off: assert property (take && !ctrl_r[0] |=> !asleep [*3])
      else $error("sleep entered without enable");
   a_idle_gates: assert property ($rose(asleep) && ctrl_r[2:1] == 2'h0 |-> clk_gates == 7'h1F)
      else $error("idle gates wrong");
   a_noise_gates: assert property ($rose(asleep) && ctrl_r[2:1] == 2'h1 |-> clk_gates == 7'h0F)
      else $error("noise reduction gates wrong");
   a_down_gates: assert property ($rose(asleep) && ctrl_r[2:1] == 2'h2 |-> clk_gates == 7'h00)
      else $error("power-down gates wrong");
   a_save_gates: assert property ($rose(asleep) && ctrl_r[2:1] == 2'h3 |-> clk_gates == 7'h05)
      else $error("power-save gates wrong");
   a_adc_kick: assert property (take && ctrl_r[0] |=>
      adc_start == ($past(adc_enabled) && !$past(ctrl_r[2])))
      else $error("conversion start wrong");
   a_idle_wake: assert property ($rose(|wake_src) && asleep && ctrl_r[2:1] == 2'h0
      && !sys_reset |=> s_hold ##1 s_resume)
      else $error("idle wake timing wrong");
   a_reset_wake: assert property ($rose(sys_reset) && asleep |-> ##[1:4] core_reset_vector)
      else $error("reset did not wake");
   a_bod_kept: assert property (asleep && !ctrl_r[2] |-> brownout_detector_on)
      else $error("detector off in shallow mode");
   a_bod_back: assert property ($fell(asleep) |-> brownout_detector_on)
      else $error("detector not back on");
endmodule : sleep_mode_controller_asserts
bind sleep_mode_controller sleep_mode_controller_asserts chk (
   .mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .sleep_instr(sleep_instr), .sys_reset(sys_reset), .adc_enabled(adc_enabled),
   .wake_src(wake_src), .clk_gates(clk_gates), .brownout_detector_on(brownout_detector_on),
   .adc_start(adc_start), .core_resume(core_resume), .core_reset_vector(core_reset_vector),
   .asleep(asleep));
`default_nettype wire

// ==== verification/core_model.sv ====
// behavioural processor core and wake sources facing the controller
`timescale 1ns/100ps
`default_nettype none
module core_model
   import sleep_pkg::*;
(
   // commands from the bench
   input wire logic mclk,
   input wire logic go,
   input wire wake_src_t req,
   // controller side
   input wire logic core_resume,
   input wire logic core_reset_vector,
   output logic sleep_instr,
   output wake_src_t wake_src = '0
);
   assign sleep_instr = go;
   // a request level is held until the core restarts, as deep modes need
   always @(posedge mclk)
      if (core_resume || core_reset_vector)
         wake_src <= '0;
      else if (|req)
         wake_src <= req;
endmodule : core_model
`default_nettype wire

// ==== verification/sleep_mode_controller_tb.sv ====
// self-checking bench for the sleep-mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) \
      begin \
         n_fail++; \
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end
module sleep_mode_controller_tb
   import sleep_pkg::*;
;
   logic mclk, rstn, wb_cyc, wb_stb, wb_we, wb_ack, go, sys_reset;
   logic sleep_instr, bod_on, adc_start, core_resume, core_reset_vector, asleep;
   logic adc_en, kick;
   logic [3:0] wb_adr;
   logic [31:0] wb_dat, rd_data, q;
   wake_src_t req, wake_src;
   clock_gates_t clk_gates;
   int n_fail, checks_done, c;
   logic [6:0] gexp [4] = '{7'h1F, 7'h0F, 7'h00, 7'h05};
   logic [9:0] wexp [4] = '{10'h001, 10'h200, 10'h002, 10'h040};
   // requests each mode must ignore: io in noise reduction and power-down, disabled compare
   logic [9:0] wbad [4] = '{10'h000, 10'h001, 10'h001, 10'h020};

   sleep_mode_controller uut (
      .mclk(mclk), .rstn(rstn), .clk_en(1'b1), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(rd_data), .wb_ack_o(wb_ack), .sleep_instr(sleep_instr),
      .sys_reset(sys_reset), .adc_enabled(adc_en), .wake_src(wake_src),
      .wake_cfg(5'h17), .timer0_async_select(1'b1),
      .clk_gates(clk_gates), .brownout_detector_on(bod_on), .adc_start(adc_start),
      .core_resume(core_resume), .core_reset_vector(core_reset_vector), .asleep(asleep));
   core_model partner (
      .mclk(mclk), .go(go), .req(req), .core_resume(core_resume),
      .core_reset_vector(core_reset_vector), .sleep_instr(sleep_instr), .wake_src(wake_src));

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task automatic timeout;
      n_fail++;
      results();
   endtask : timeout

   // one idle cycle first, so back-to-back calls never drop and raise cyc together
   task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat <= d;
      do
      begin
         @(posedge mclk);
         n++;
         if (n > 20)
            timeout();
      end
      while (wb_ack !== 1'b1);
      q = rd_data;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb_xfer

   task automatic wait_hi(ref logic s, input int lim);
      c = 0;
      while (s !== 1'b1)
      begin
         @(posedge mclk);
         c++;
         if (c > lim)
            timeout();
      end
   endtask : wait_hi

   task automatic sleep_now;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      kick = adc_start;
      wait_hi(asleep, 10);
   endtask : sleep_now

   task automatic wake(input logic [9:0] w, input int lim);
      req <= w;
      @(posedge mclk);
      req <= '0;
      wait_hi(core_resume, lim);
   endtask : wake

   initial
   begin
      {rstn, wb_cyc, wb_stb, wb_we, go, sys_reset} = 6'h00;
      wb_adr = 4'h0;
      wb_dat = 32'h0;
      req = '0;
      adc_en = 1'b1;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      wb_xfer(1'b0, MICRO_CTRL_ADDR, 32'h0);
      `CHK(q, 32'h0)
      wb_xfer(1'b0, STATUS_ADDR, 32'h0);
      `CHK(q[7:0], 8'h81)
      wb_xfer(1'b0, CONFIG_ADDR, 32'h0);
      `CHK(q, 32'h1000)
      wb_xfer(1'b0, 4'h2, 32'h0);
      `CHK(q, 32'h0)
      `CHK(clk_gates, 7'h7F)
      wb_xfer(1'b1, CONFIG_ADDR, 32'h0500);
      $display("test reset done");
      for (int m = 0; m < 4; m++)
      begin
         wb_xfer(1'b1, SLEEP_CTRL_ADDR, {29'h0, m[1:0], 1'b1});
         adc_en <= (m != 1);
         sleep_now();
         `CHK(clk_gates, gexp[m])
         `CHK(kick, m == 0)
         if (m > 0)
         begin
            req <= wbad[m];
            repeat (20) @(posedge mclk);
            `CHK(asleep, 1'b1)
         end
         wake(wexp[m], 100);
         `CHK(c >= ((m > 1) ? 9 : 4), 1'b1)
      end
      $display("test modes done");
      wb_xfer(1'b1, SLEEP_CTRL_ADDR, 32'h5);
      wb_xfer(1'b1, MICRO_CTRL_ADDR, 32'h60);
      wb_xfer(1'b1, MICRO_CTRL_ADDR, 32'h40);
      sleep_now();
      @(posedge mclk);
      `CHK(bod_on, 1'b0)
      wake(10'h002, 2000);
      `CHK(c >= BOD_WAKE_CYC, 1'b1)
      `CHK(bod_on, 1'b1)
      wb_xfer(1'b1, SLEEP_CTRL_ADDR, 32'h1);
      wb_xfer(1'b1, MICRO_CTRL_ADDR, 32'h60);
      wb_xfer(1'b1, MICRO_CTRL_ADDR, 32'h40);
      sleep_now();
      @(posedge mclk);
      `CHK(bod_on, 1'b1)
      wake(10'h001, 100);
      wb_xfer(1'b0, MICRO_CTRL_ADDR, 32'h0);
      `CHK(q[BROWNOUT_SLEEP_OFF_POS], 1'b0)
      $display("test brownout done");
      wb_xfer(1'b1, SLEEP_CTRL_ADDR, 32'h4);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK(asleep, 1'b0)
      wb_xfer(1'b1, SLEEP_CTRL_ADDR, 32'h5);
      sleep_now();
      sys_reset <= 1'b1;
      wait_hi(core_reset_vector, 50);
      sys_reset <= 1'b0;
      repeat (10) @(posedge mclk);
      wb_xfer(1'b0, STATUS_ADDR, 32'h0);
      `CHK(q[4:0], 5'h01)
      $display("test enable and reset done");
      results();
   end
endmodule : sleep_mode_controller_tb
`default_nettype wire
